// File: rtl/icc_capture_channel.sv
// input capture channel: bus slave, counter, captures and interrupts
`timescale 1ns/1ps

// Functional notes
// - clear select on capture b zeroes the counter at each b capture
// - pin a both-edge code captures counter on rising and falling edges
// - pin b falling-edge code captures counter on falling edges only
// - each pin has its own filter enable; cleared passes raw edges
// - 3-bit prescaler select picks count clock; zero is module clock
// - status keeps a sticky flag per capture; capture requests leave as direct pulses
// - module stop keeps channel idle; software clears it before setup
module icc_capture_channel (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_B,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic        I_CAPTURE_PIN_A,
    input  wire logic        I_CAPTURE_PIN_B,
    output logic             O_CAPTURE_A_IRQ,
    output logic             O_CAPTURE_B_IRQ,
    output logic             O_IRQ
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------

    // every flop of this module lives in this one record; filters and prescaler keep their own
    typedef struct packed {
        logic                       ack;
        logic [31:0]                rdat;
        logic [icc_pkg::CTRL_W-1:0] ctrl;
        logic [icc_pkg::IO_W-1:0]   io;
        logic [15:0]                count;
        logic [15:0]                cap_a;
        logic [15:0]                cap_b;
        logic [1:0]                 status;
        logic [1:0]                 mask;
        logic                       irq_a;
        logic                       irq_b;
    } icc_chan_state_s;

    // module stop is set out of reset, so nothing moves until software
    localparam icc_chan_state_s ST_RESET = '{
        ack:    1'b0,
        rdat:   32'h0000_0000,
        ctrl:   icc_pkg::CTRL_RESET,
        io:     icc_pkg::IO_RESET,
        count:  icc_pkg::COUNT_RESET,
        cap_a:  icc_pkg::COUNT_RESET,
        cap_b:  icc_pkg::COUNT_RESET,
        status: icc_pkg::EV_RESET,
        mask:   icc_pkg::EV_RESET,
        irq_a:  1'b0,
        irq_b:  1'b0
    };

    icc_chan_state_s r;
    icc_chan_state_s next_r;

    // ---------------------------------------------------------------
    // control field decode
    // ---------------------------------------------------------------

    logic       stopped;
    logic       active;
    logic       start;
    logic [2:0] psc_sel;
    logic [2:0] clr_sel;
    logic       nf_a;
    logic       nf_b;
    logic       ie_a;
    logic       ie_b;
    logic [3:0] io_a;
    logic [3:0] io_b;

    // plain slices of the control and io registers
    assign stopped = r.ctrl[icc_pkg::CTRL_STOP];
    assign active  = ~stopped;
    assign start   = r.ctrl[icc_pkg::CTRL_START];
    assign psc_sel = r.ctrl[icc_pkg::CTRL_PSC_LSB +: 3];
    assign clr_sel = r.ctrl[icc_pkg::CTRL_CLR_LSB +: 3];
    assign nf_a    = r.ctrl[icc_pkg::CTRL_NF_A];
    assign nf_b    = r.ctrl[icc_pkg::CTRL_NF_B];
    assign ie_a    = r.ctrl[icc_pkg::CTRL_IE_A];
    assign ie_b    = r.ctrl[icc_pkg::CTRL_IE_B];
    assign io_a    = r.io[icc_pkg::IO_A_LSB +: 4];
    assign io_b    = r.io[icc_pkg::IO_B_LSB +: 4];

    // ---------------------------------------------------------------
    // pin conditioning and count clock
    // ---------------------------------------------------------------

    icc_pkg::icc_edge_s edge_a;
    icc_pkg::icc_edge_s edge_b;
    logic               tick;

    // pin a: own filter enable
    icc_pin_filter u_pin_a (
        .i_clk       (I_MCLK),
        .i_rst_b     (I_RST_B),
        .i_pin       (I_CAPTURE_PIN_A),
        .i_filter_en (nf_a),
        .o_edge      (edge_a)
    );

    // pin b: own filter enable
    icc_pin_filter u_pin_b (
        .i_clk       (I_MCLK),
        .i_rst_b     (I_RST_B),
        .i_pin       (I_CAPTURE_PIN_B),
        .i_filter_en (nf_b),
        .o_edge      (edge_b)
    );

    // counts only when out of stop and started
    icc_prescaler u_psc (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_run   (active & start),
        .i_sel   (psc_sel),
        .o_tick  (tick)
    );

    // ---------------------------------------------------------------
    // capture qualification
    // ---------------------------------------------------------------

    logic hit_a;
    logic hit_b;
    logic clr_hit;

    // edges are dropped, not queued, while the module is stopped
    assign hit_a = active & icc_pkg::icc_io_hit(io_a, edge_a);
    assign hit_b = active & icc_pkg::icc_io_hit(io_b, edge_b);

    // counter clear follows the selected capture
    always_comb begin
        clr_hit = 1'b0;
        if (clr_sel == icc_pkg::CLR_ON_B) begin
            clr_hit = hit_b;
        end else if (clr_sel == icc_pkg::CLR_ON_A) begin
            clr_hit = hit_a;
        end
    end

    // ---------------------------------------------------------------
    // wishbone decode
    // ---------------------------------------------------------------

    logic        bus_req;
    logic        wr;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic        wr_ctrl;
    logic        wr_io;
    logic        wr_count;
    logic        wr_cap_a;
    logic        wr_cap_b;
    logic        wr_status;
    logic        wr_mask;
    logic [1:0]  w1c;

    assign bus_req = I_WB_CYC & I_WB_STB;
    // a write lands on the edge where the master sees ack
    assign wr      = bus_req & I_WB_WE & r.ack;

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (I_WB_ADR == icc_pkg::ADR_CTRL) begin
            rd_word[icc_pkg::CTRL_W-1:0] = r.ctrl;
        end else if (I_WB_ADR == icc_pkg::ADR_IO) begin
            rd_word[icc_pkg::IO_W-1:0] = r.io;
        end else if (I_WB_ADR == icc_pkg::ADR_COUNT) begin
            rd_word[15:0] = r.count;
        end else if (I_WB_ADR == icc_pkg::ADR_CAP_A) begin
            rd_word[15:0] = r.cap_a;
        end else if (I_WB_ADR == icc_pkg::ADR_CAP_B) begin
            rd_word[15:0] = r.cap_b;
        end else if (I_WB_ADR == icc_pkg::ADR_STATUS) begin
            rd_word[1:0] = r.status;
        end else if (I_WB_ADR == icc_pkg::ADR_MASK) begin
            rd_word[1:0] = r.mask;
        end
    end

    // merged write word keeps unselected byte lanes
    assign wr_word = icc_pkg::icc_merge(rd_word, I_WB_DAT, I_WB_SEL);

    // write strobes; channel setup is locked while stopped
    always_comb begin
        wr_ctrl   = 1'b0;
        wr_io     = 1'b0;
        wr_count  = 1'b0;
        wr_cap_a  = 1'b0;
        wr_cap_b  = 1'b0;
        wr_status = 1'b0;
        wr_mask   = 1'b0;
        if (!wr) begin
            wr_ctrl = 1'b0;
        end else if (I_WB_ADR == icc_pkg::ADR_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (I_WB_ADR == icc_pkg::ADR_IO) begin
            wr_io = active;
        end else if (I_WB_ADR == icc_pkg::ADR_COUNT) begin
            wr_count = active;
        end else if (I_WB_ADR == icc_pkg::ADR_CAP_A) begin
            wr_cap_a = active;
        end else if (I_WB_ADR == icc_pkg::ADR_CAP_B) begin
            wr_cap_b = active;
        end else if (I_WB_ADR == icc_pkg::ADR_STATUS) begin
            wr_status = 1'b1;
        end else if (I_WB_ADR == icc_pkg::ADR_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // write-one-to-clear only through the low byte lane
    assign w1c = wr_status ? (I_WB_DAT[1:0] & {2{I_WB_SEL[0]}}) : 2'h0;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------

    always_comb begin
        next_r = r;

        // single-cycle ack; drops the cycle after it was given
        next_r.ack = bus_req & ~r.ack;
        next_r.rdat = 32'h0000_0000;
        if (bus_req && !r.ack && !I_WB_WE) begin
            next_r.rdat = rd_word;
        end

        // configuration
        if (wr_ctrl) begin
            next_r.ctrl = wr_word[icc_pkg::CTRL_W-1:0];
        end
        if (wr_io) begin
            next_r.io = wr_word[icc_pkg::IO_W-1:0];
        end
        if (wr_mask) begin
            next_r.mask = wr_word[1:0];
        end

        // captures take the pre-increment count; they beat a bus write
        if (hit_a) begin
            next_r.cap_a = r.count;
        end else if (wr_cap_a) begin
            next_r.cap_a = wr_word[15:0];
        end
        if (hit_b) begin
            next_r.cap_b = r.count;
        end else if (wr_cap_b) begin
            next_r.cap_b = wr_word[15:0];
        end

        // clear first, then software load, then count tick
        if (clr_hit) begin
            next_r.count = icc_pkg::COUNT_RESET;
        end else if (wr_count) begin
            next_r.count = wr_word[15:0];
        end else if (tick) begin
            next_r.count = r.count + 16'h0001;
        end

        // direct capture requests, one pulse each, nothing latched
        next_r.irq_a = hit_a & ie_a;
        next_r.irq_b = hit_b & ie_b;

        // system status: set wins over a same-cycle clear
        next_r.status = (r.status & ~w1c);
        next_r.status[icc_pkg::EV_A] = next_r.status[icc_pkg::EV_A] | hit_a;
        next_r.status[icc_pkg::EV_B] = next_r.status[icc_pkg::EV_B] | hit_b;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            r <= ST_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------

    // all outputs come straight from flops or a gate of flops
    assign O_WB_ACK        = r.ack;
    assign O_WB_DAT        = r.rdat;
    assign O_CAPTURE_A_IRQ = r.irq_a;
    assign O_CAPTURE_B_IRQ = r.irq_b;
    // level interrupt, stays high until the status bit is cleared or its mask bit is written to zero
    assign O_IRQ           = |(r.status & r.mask);

endmodule : icc_capture_channel

// File: common/icc_pkg.sv
// shared constants, types and helpers for the input capture channel
package icc_pkg;

    // ---------------------------------------------------------------
    // register map, byte addresses on the 32-bit bus
    // ---------------------------------------------------------------
    localparam logic [7:0]  ADR_CTRL     = 8'h00;
    localparam logic [7:0]  ADR_IO       = 8'h04;
    localparam logic [7:0]  ADR_COUNT    = 8'h08;
    localparam logic [7:0]  ADR_CAP_A    = 8'h0C;
    localparam logic [7:0]  ADR_CAP_B    = 8'h10;
    localparam logic [7:0]  ADR_STATUS   = 8'h14;
    localparam logic [7:0]  ADR_MASK     = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int          CTRL_W       = 12;
    localparam int          CTRL_STOP    = 0;
    localparam int          CTRL_START   = 1;
    localparam int          CTRL_PSC_LSB = 2;
    localparam int          CTRL_CLR_LSB = 5;
    localparam int          CTRL_NF_A    = 8;
    localparam int          CTRL_NF_B    = 9;
    localparam int          CTRL_IE_A    = 10;
    localparam int          CTRL_IE_B    = 11;
    localparam int          IO_W         = 8;
    localparam int          IO_A_LSB     = 0;
    localparam int          IO_B_LSB     = 4;
    localparam int          EV_A         = 0;
    localparam int          EV_B         = 1;

    // ---------------------------------------------------------------
    // reset values and timing counts
    // ---------------------------------------------------------------
    localparam logic [11:0] CTRL_RESET   = 12'h001;
    localparam logic [7:0]  IO_RESET     = 8'h00;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [1:0]  EV_RESET     = 2'h0;
    localparam int          NF_SAMPLES   = 3;
    localparam logic [1:0]  NF_LAST      = 2'(NF_SAMPLES - 1);
    localparam logic [5:0]  DIV1_MASK    = 6'h00;
    localparam logic [5:0]  DIV4_MASK    = 6'h03;
    localparam logic [5:0]  DIV16_MASK   = 6'h0F;
    localparam logic [5:0]  DIV64_MASK   = 6'h3F;

    // ---------------------------------------------------------------
    // codes
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        IO_CAP_RISE  = 4'b1000,
        IO_CAP_FALL  = 4'b1001,
        IO_CAP_BOTH  = 4'b1010,
        IO_CAP_BOTHX = 4'b1011
    } icc_io_e;

    typedef enum logic [2:0] {
        CLR_NONE = 3'b000,
        CLR_ON_A = 3'b001,
        CLR_ON_B = 3'b010
    } icc_clr_e;

    typedef enum logic [2:0] {
        PSC_DIV1  = 3'b000,
        PSC_DIV4  = 3'b001,
        PSC_DIV16 = 3'b010,
        PSC_DIV64 = 3'b011
    } icc_psc_e;

    typedef struct packed {
        logic rise;
        logic fall;
    } icc_edge_s;

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] icc_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : icc_merge

    // does this edge qualify under the pin's io control code
    function automatic logic icc_io_hit(input logic [3:0] io,
                                        input icc_edge_s   e);
        logic hit;
        hit = 1'b0;
        case (io)
            IO_CAP_RISE:              hit = e.rise;
            IO_CAP_FALL:              hit = e.fall;
            IO_CAP_BOTH, IO_CAP_BOTHX: hit = e.rise | e.fall;
            default:                  hit = 1'b0;
        endcase
        return hit;
    endfunction : icc_io_hit

endpackage : icc_pkg

// File: rtl/icc_pin_filter.sv
// pin synchroniser, optional noise filter and edge detector
`timescale 1ns/1ps

module icc_pin_filter (
    input  wire logic          i_clk,
    input  wire logic          i_rst_b,
    input  wire logic          i_pin,
    input  wire logic          i_filter_en,
    output icc_pkg::icc_edge_s o_edge
);
    typedef struct packed {
        logic               meta;
        logic               sync;
        logic               filt;
        logic [1:0]         cnt;
        logic               last;
        icc_pkg::icc_edge_s edge_q;
    } icc_filt_state_s;

    icc_filt_state_s r;
    icc_filt_state_s next_r;
    logic            lvl;

    // sync, filter and edge detect; meta is read by sync only
    always_comb begin
        next_r = r;
        next_r.meta = i_pin;
        next_r.sync = r.meta;
        if (!i_filter_en || r.sync == r.filt) begin
            next_r.cnt = 2'h0;
            next_r.filt = r.sync;    // tracks so enabling makes no edge
        end else if (r.cnt == icc_pkg::NF_LAST) begin
            next_r.cnt = 2'h0;
            next_r.filt = r.sync;
        end else begin
            next_r.cnt = r.cnt + 2'h1;
        end
        lvl = i_filter_en ? r.filt : r.sync;
        next_r.last = lvl;
        next_r.edge_q.rise = lvl & ~r.last;
        next_r.edge_q.fall = ~lvl & r.last;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_edge = r.edge_q;

endmodule : icc_pin_filter

// File: rtl/icc_prescaler.sv
// count clock prescaler driven by the 3-bit select
`timescale 1ns/1ps

module icc_prescaler (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_run,
    input  wire logic [2:0] i_sel,
    output logic            o_tick
);
    typedef struct packed {
        logic [5:0] div;
    } icc_psc_state_s;

    icc_psc_state_s r;
    icc_psc_state_s next_r;
    logic [5:0]     mask;
    logic           valid;

    // divider free-runs while counting, restarts when stopped
    always_comb begin
        next_r = r;
        mask = icc_pkg::DIV1_MASK;
        valid = 1'b1;
        case (i_sel)
            icc_pkg::PSC_DIV1:  mask = icc_pkg::DIV1_MASK;
            icc_pkg::PSC_DIV4:  mask = icc_pkg::DIV4_MASK;
            icc_pkg::PSC_DIV16: mask = icc_pkg::DIV16_MASK;
            icc_pkg::PSC_DIV64: mask = icc_pkg::DIV64_MASK;
            default:            valid = 1'b0; // no external clock here
        endcase
        o_tick = i_run & valid & ((r.div & mask) == mask);
        next_r.div = i_run ? r.div + 6'h01 : 6'h00;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule : icc_prescaler

// File: testbench/icc_capture_assertions.sv
// port-level assertion checker for the input capture channel
`timescale 1ns/1ps

module icc_capture_assertions (
    input wire logic        I_MCLK,
    input wire logic        I_RST_B,
    input wire logic        I_WB_CYC,
    input wire logic        I_WB_STB,
    input wire logic        I_WB_WE,
    input wire logic [7:0]  I_WB_ADR,
    input wire logic [3:0]  I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [31:0] O_WB_DAT,
    input wire logic        O_WB_ACK,
    input wire logic        I_CAPTURE_PIN_A,
    input wire logic        I_CAPTURE_PIN_B,
    input wire logic        O_CAPTURE_A_IRQ,
    input wire logic        O_CAPTURE_B_IRQ,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    // --------------------------------------------------------------
    // cause sequences: pin moves seen 4 (raw) or 7 (filtered) edges on
    // --------------------------------------------------------------
    sequence s_req_new;
        $rose(I_WB_CYC && I_WB_STB);
    endsequence
    sequence s_a_moved;
        ($past(I_CAPTURE_PIN_A, 4) != $past(I_CAPTURE_PIN_A, 5)) ||
        ($past(I_CAPTURE_PIN_A, 7) != $past(I_CAPTURE_PIN_A, 8));
    endsequence
    sequence s_b_fell;
        $past(I_CAPTURE_PIN_B, 5) && !$past(I_CAPTURE_PIN_B, 4);
    endsequence

    // bus handshake: fixed one-cycle answer, single pulse, idle data zero
    a_ack_answers: assert property (s_req_new |=> O_WB_ACK)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held longer than one cycle");
    a_ack_in_req: assert property (O_WB_ACK |->
        I_WB_CYC && I_WB_STB && $past(I_WB_CYC && I_WB_STB))
        else $error("ack outside a request");
    a_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0000_0000)
        else $error("read data not zero outside ack");

    // capture requests only follow a qualifying pin edge
    a_irq_a_cause: assert property (O_CAPTURE_A_IRQ |-> s_a_moved)
        else $error("capture a request without a pin a edge");
    a_irq_b_fall: assert property (O_CAPTURE_B_IRQ |-> s_b_fell)
        else $error("capture b request without a pin b fall");
    a_pulse_a_one: assert property (
        O_CAPTURE_A_IRQ |=> !O_CAPTURE_A_IRQ)
        else $error("capture a request wider than one cycle");
    a_pulse_b_one: assert property (
        O_CAPTURE_B_IRQ |=> !O_CAPTURE_B_IRQ)
        else $error("capture b request wider than one cycle");
    // summary line only drops through a register write
    a_irq_drop_wr: assert property (
        $fell(O_IRQ) |-> $past(O_WB_ACK && I_WB_WE))
        else $error("summary interrupt dropped without a write");
endmodule : icc_capture_assertions

bind icc_capture_channel icc_capture_assertions u_chk (
    .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
    .O_WB_ACK(O_WB_ACK), .I_CAPTURE_PIN_A(I_CAPTURE_PIN_A),
    .I_CAPTURE_PIN_B(I_CAPTURE_PIN_B), .O_CAPTURE_A_IRQ(O_CAPTURE_A_IRQ),
    .O_CAPTURE_B_IRQ(O_CAPTURE_B_IRQ), .O_IRQ(O_IRQ)
);

// File: testbench/icc_pin_model.sv
// behavioural model of the external signals on the two capture pins
`timescale 1ns/1ps

module icc_pin_model (
    output logic o_pin_a,
    output logic o_pin_b
);
    // idle high, so the first move on each pin is a falling edge
    initial begin
        o_pin_a = 1'b1;
        o_pin_b = 1'b1;
    end

    // called just after a clock edge; the level holds until the next call,
    // so pulse width is set by the caller in whole cycles
    task automatic drive(input logic b, input logic v);
        if (b) begin
            o_pin_b <= v;
        end else begin
            o_pin_a <= v;
        end
    endtask : drive
endmodule : icc_pin_model

// File: testbench/tb.sv
// self-checking bench for the input capture channel
`timescale 1ns/1ps

module tb;
    logic        mclk   = 1'b0;
    logic        rst_b  = 1'b0;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [3:0]  sel    = 4'h0;
    logic [31:0] wdat   = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        pin_a;
    logic        pin_b;
    logic        irq_a;
    logic        irq_b;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] ea;
    logic [31:0] eb;
    int          err_count = 0;
    int          checked   = 0;
    int          cyc_n     = 0;
    int          st, lat, w0, p, q, f, pa;

    icc_capture_channel dut (
        .I_MCLK(mclk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_CAPTURE_PIN_A(pin_a),
        .I_CAPTURE_PIN_B(pin_b), .O_CAPTURE_A_IRQ(irq_a),
        .O_CAPTURE_B_IRQ(irq_b), .O_IRQ(irq)
    );
    icc_pin_model pins (.o_pin_a(pin_a), .o_pin_b(pin_b));

    // 200 MHz clock and an edge stamp used to predict counter values
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) cyc_n <= cyc_n + 1;

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task report_and_stop;
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // classic cycle; stamp st is the edge where ack is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (ack === 1'b1) break;
        end
        rd = rdat;
        st = cyc_n;
        if (n == 20) begin
            err_count++;
            report_and_stop();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rd_chk

    // move one pin, then measure cycles until its request pulse (0: none)
    task edge_pin(input logic b, input logic v, input int max);
        int n;
        @(posedge mclk);
        p = cyc_n;
        pins.drive(b, v);
        lat = 0;
        for (n = 1; n <= max; n++) begin
            @(posedge mclk);
            if ((b ? irq_b : irq_a) === 1'b1) begin
                lat = n;
                break;
            end
        end
    endtask : edge_pin

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        rd_chk(icc_pkg::ADR_CTRL, 32'(icc_pkg::CTRL_RESET));
        for (int i = 1; i < 8; i++) rd_chk(8'(4 * i), 32'h0000_0000);
        // setup registers locked while stopped; unmapped place ignored
        bus(1'b1, icc_pkg::ADR_IO, 32'h0000_009A);
        rd_chk(icc_pkg::ADR_IO, 32'h0000_0000);
        bus(1'b1, icc_pkg::ADR_COUNT, 32'h0000_1234);
        rd_chk(icc_pkg::ADR_COUNT, 32'h0000_0000);
        bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd_chk(8'h1C, 32'h0000_0000);
        // out of stop but not started, clear on b, both irq enables; a both edges, b falling only
        bus(1'b1, icc_pkg::ADR_CTRL, 32'h0000_0C40);
        bus(1'b1, icc_pkg::ADR_IO, 32'h0000_009A);
        rd_chk(icc_pkg::ADR_IO, 32'h0000_009A);
        bus(1'b1, icc_pkg::ADR_COUNT, 32'h0000_0100);
        bus(1'b1, icc_pkg::ADR_MASK, 32'h0000_0003);
        rd_chk(icc_pkg::ADR_COUNT, 32'h0000_0100);
        bus(1'b1, icc_pkg::ADR_CTRL, 32'h0000_0C42);
        w0 = st;
        edge_pin(1'b0, 1'b0, 10);
        chk(32'(lat), 32'h0000_0005);
        rd_chk(icc_pkg::ADR_CAP_A, 32'(16'(256 + p + 3 - w0)));
        edge_pin(1'b0, 1'b1, 10);
        chk(32'(lat), 32'h0000_0005);
        ea = 32'(16'(256 + p + 3 - w0));
        rd_chk(icc_pkg::ADR_CAP_A, ea);
        edge_pin(1'b1, 1'b0, 10);
        chk(32'(lat), 32'h0000_0005);
        q = p;
        eb = 32'(16'(256 + p + 3 - w0));
        edge_pin(1'b1, 1'b1, 10);
        chk(32'(lat), 32'h0000_0000);
        rd_chk(icc_pkg::ADR_CAP_B, eb);
        bus(1'b1, icc_pkg::ADR_CTRL, 32'h0000_0C40);
        f = st - q - 4;
        rd_chk(icc_pkg::ADR_COUNT, 32'(16'(f)));
        // summary interrupt: sticky status, write-one clear, mask gating
        rd_chk(icc_pkg::ADR_STATUS, 32'h0000_0003);
        chk(32'(irq), 32'h0000_0001);
        bus(1'b1, icc_pkg::ADR_STATUS, 32'h0000_0001);
        rd_chk(icc_pkg::ADR_STATUS, 32'h0000_0002);
        bus(1'b1, icc_pkg::ADR_MASK, 32'h0000_0001);
        @(posedge mclk);
        chk(32'(irq), 32'h0000_0000);
        bus(1'b1, icc_pkg::ADR_STATUS, 32'h0000_0002);
        rd_chk(icc_pkg::ADR_STATUS, 32'h0000_0000);
        // filter on pin a only, no clear, b request disabled
        bus(1'b1, icc_pkg::ADR_CTRL, 32'h0000_0502);
        w0 = st;
        edge_pin(1'b0, 1'b0, 1);
        chk(32'(lat), 32'h0000_0000);
        edge_pin(1'b0, 1'b1, 12);
        chk(32'(lat), 32'h0000_0000);
        rd_chk(icc_pkg::ADR_CAP_A, ea);
        edge_pin(1'b0, 1'b0, 12);
        chk(32'(lat), 32'h0000_0008);
        pa = p;
        edge_pin(1'b1, 1'b0, 10);
        chk(32'(lat), 32'h0000_0000);
        rd_chk(icc_pkg::ADR_CAP_A, 32'(16'(f + pa + 6 - w0)));
        rd_chk(icc_pkg::ADR_CAP_B, 32'(16'(f + p + 3 - w0)));
        rd_chk(icc_pkg::ADR_STATUS, 32'h0000_0003);
        report_and_stop();
    end
endmodule : tb
